// *** src/lxt_regs.svh ***
// Register offsets, field positions, reset values and match constants of the LAN trap block.
`ifndef LXT_REGS_SVH
`define LXT_REGS_SVH
`define LXT_ADDR_W 8
`define LXT_OFF_TXST2 8'hBC
`define LXT_OFF_MODE 8'hC0
`define LXT_OFF_DAL 8'hC2
`define LXT_OFF_DAM 8'hC4
`define LXT_OFF_DAH 8'hC6
`define LXT_OFF_DAX 8'hC8
`define LXT_OFF_ETYP 8'hCA
`define LXT_TS_ERR 15
`define LXT_TS_JAB 14
`define LXT_TS_FLUSH 13
`define LXT_TS_LOC 11
`define LXT_TS_NOC 10
`define LXT_TS_LC 9
`define LXT_TS_EC 8
`define LXT_TS_CC_LSB 3
`define LXT_TS_EXD 2
`define LXT_TS_UFE 1
`define LXT_TS_DEF 0
`define LXT_MD_MGMT 9
`define LXT_MD_BCAST 8
`define LXT_MD_SRC 4
`define LXT_MD_VLAN 3
`define LXT_MD_ETYP 2
`define LXT_MD_DA 1
`define LXT_MD_DUAL 0
`define LXT_MODE_WMASK 16'h031F
`define LXT_DAX_WMASK 16'h00FF
`define LXT_RST_TXST2 16'h0000
`define LXT_RST_MODE 16'h0000
`define LXT_RST_DA 16'h0000
`define LXT_RST_DAX 16'h0000
`define LXT_RST_ETYP 16'h0000
`define LXT_CC_MAX 4'hF
`define LXT_MGMT_PFX 24'h0180C2
`define LXT_BCAST_DA 48'hFFFFFFFFFFFF
`endif

// *** src/lxt_pkg.sv ***
// Types shared by the LAN trap and transmit status modules.
package lxt_pkg;
   typedef struct packed {
      logic err; logic jab; logic flush; logic rsv12;
      logic loc; logic noc; logic lc; logic ec; logic rsv7;
      logic [3:0] cc; logic exd; logic ufe; logic def;
   } lxt_txst_t;
   typedef struct packed {
      logic [47:0] da; logic [15:0] etype; logic vlan_hit; logic queue_fwd;
   } lxt_hdr_t;
   typedef struct packed {logic extract; logic fwd; logic done;} lxt_trap_st_t;
endpackage

// *** src/lxt_trap_if.sv ***
// Configuration and frame header path between the register bank and the classifier.
interface lxt_trap_if;
   logic mgmt_en;
   logic bcast_en;
   logic vlan_en;
   logic etype_en;
   logic da_en;
   logic [47:0] addr;
   logic [7:0] mask;
   logic [15:0] etype;
   logic hv;
   lxt_pkg::lxt_hdr_t hdr;
   logic extract;
   logic fwd;
   logic done;
   modport trap(input mgmt_en, bcast_en, vlan_en, etype_en, da_en, addr, mask, etype, hv, hdr,
      output extract, fwd, done);
   modport ctl(output mgmt_en, bcast_en, vlan_en, etype_en, da_en, addr, mask, etype, hv, hdr,
      input extract, fwd, done);
endinterface

// *** src/lxt_txstat.sv ***
// Real-time transmit status of LAN port 2.
`include "lxt_regs.svh"
module lxt_txstat (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Transmit MAC events.
   input wire logic i_start,
   input wire logic [8:0] i_err,
   input wire logic i_coll,
   input wire logic i_defer,
   // Status word.
   output lxt_pkg::lxt_txst_t o_st
);
   lxt_pkg::lxt_txst_t st_ff;
   lxt_pkg::lxt_txst_t nxt_st;
   logic [3:0] base;
   always_comb begin
      nxt_st = st_ff;
      base = st_ff.cc;
      if (i_start) begin
         nxt_st = '0;
         base = 4'h0;
      end
      // Events are applied after the clear so a fault in the start cycle is kept.
      {nxt_st.jab, nxt_st.flush, nxt_st.loc, nxt_st.noc, nxt_st.lc, nxt_st.ec, nxt_st.exd,
         nxt_st.ufe} = {nxt_st.jab, nxt_st.flush, nxt_st.loc, nxt_st.noc, nxt_st.lc,
         nxt_st.ec, nxt_st.exd, nxt_st.ufe} | i_err[7:0];
      if (i_coll && base != `LXT_CC_MAX) begin
         nxt_st.cc = base + 4'h1;
      end else begin
         nxt_st.cc = base;
      end
      nxt_st.def = i_defer & i_err[8];
      nxt_st.err = nxt_st.jab | nxt_st.flush | nxt_st.loc | nxt_st.noc | nxt_st.lc
         | nxt_st.ec | nxt_st.exd;
      nxt_st.rsv12 = 1'b0;
      nxt_st.rsv7 = 1'b0;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) st_ff <= '0;
      else st_ff <= nxt_st;
   end
   assign o_st = st_ff;
endmodule

// *** src/lxt_trap.sv ***
// Classifier that diverts received LAN frames to the extract queue.
`include "lxt_regs.svh"
module lxt_trap (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Configuration, header and result.
   lxt_trap_if.trap t
);
   lxt_pkg::lxt_trap_st_t st_ff;
   lxt_pkg::lxt_trap_st_t nxt_st;
   logic [47:0] care;
   logic hit;
   always_comb begin
      care = {40'hFFFFFFFFFF, ~t.mask};
      hit = (t.mgmt_en && t.hdr.da[47:24] == `LXT_MGMT_PFX)
         || (t.bcast_en && t.hdr.da == `LXT_BCAST_DA)
         || (t.vlan_en && t.hdr.vlan_hit)
         || (t.etype_en && t.hdr.etype == t.etype)
         || (t.da_en && ((t.hdr.da ^ t.addr) & care) == 48'h0);
      nxt_st.extract = t.hv & hit;
      nxt_st.fwd = t.hv & t.hdr.queue_fwd & ~hit;
      nxt_st.done = t.hv;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) st_ff <= '0;
      else st_ff <= nxt_st;
   end
   assign t.extract = st_ff.extract;
   assign t.fwd = st_ff.fwd;
   assign t.done = st_ff.done;
endmodule

// *** src/lxt_top.sv ***
// LAN port mode, extract trap and port 2 transmit status register bank.
//
// Notes on behaviour
// - Error summary reads one on any listed error except transmit data underflow.
// - Jabber timeout failure sets its flag.
// - Software flush of a frame sets its flag.
// - Carrier lost mid-frame sets its flag.
// - No carrier at attempt sets its flag.
// - Late collision abort sets its flag.
// - More than sixteen collisions sets its flag.
// - Collision count of current frame in bits 6:3.
// - Too long deferral sets its flag.
// - Transmit data underflow sets its flag.
// - Deferring flag follows carrier hold-off, half duplex.
// - Traps combine; extract beats queue forwarding.
// - Bridge multicast prefix goes to extract.
// - All-ones destination goes to extract.
// - Source select picks port 1 or 2; port 2 only in dual port mode.
// - VLAN table hit diverts when enabled.
// - Matching protocol type diverts when enabled.
// - Masked destination match diverts when enabled.
// - Trap address built from three 16-bit registers.
// - Mask bits make low address bits don't-care.
// - Mode bit picks single or dual port.
// - Protocol type low byte sits in bits 7:0.
//
// Implementation choice: the plain strobed port.
`include "lxt_regs.svh"
module lxt_top (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Register port.
   input wire logic [`LXT_ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Port 2 transmit MAC events.
   input wire logic i_tx_attempt,
   input wire logic i_tx_jabber,
   input wire logic i_tx_flushed,
   input wire logic i_tx_carrier_lost,
   input wire logic i_tx_no_carrier,
   input wire logic i_tx_late_coll,
   input wire logic i_tx_excess_coll,
   input wire logic i_tx_collision,
   input wire logic i_tx_excess_deferral,
   input wire logic i_tx_underflow,
   input wire logic i_tx_deferring,
   input wire logic i_half_duplex,
   // Port 1 received header.
   input wire logic i_rx1_valid,
   input wire logic [47:0] i_rx1_da,
   input wire logic [15:0] i_rx1_etype,
   input wire logic i_rx1_vlan_hit,
   input wire logic i_rx1_queue_fwd,
   // Port 2 received header.
   input wire logic i_rx2_valid,
   input wire logic [47:0] i_rx2_da,
   input wire logic [15:0] i_rx2_etype,
   input wire logic i_rx2_vlan_hit,
   input wire logic i_rx2_queue_fwd,
   // Port mode and classification results.
   output logic o_dual_port_select,
   output logic o_gige_allowed,
   output logic o_rx_extract,
   output logic o_rx_queue_fwd,
   output logic o_rx_done
);
   // -------------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] dal;
      logic [15:0] dam;
      logic [15:0] dah;
      logic [15:0] dax;
      logic [15:0] etyp;
      logic [15:0] rdata;
      logic gige_ok;
   } lxt_top_st_t;

   lxt_top_st_t st_ff;
   lxt_top_st_t nxt_st;
   lxt_pkg::lxt_txst_t txst;
   lxt_pkg::lxt_hdr_t hdr1;
   lxt_pkg::lxt_hdr_t hdr2;
   logic src_port2;
   logic [8:0] tx_err;
   lxt_trap_if tif ();

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdata = 16'h0000;
      if (i_wr) begin
         unique case (i_addr)
            `LXT_OFF_MODE: nxt_st.mode = i_wdata & `LXT_MODE_WMASK;
            `LXT_OFF_DAL: nxt_st.dal = i_wdata;
            `LXT_OFF_DAM: nxt_st.dam = i_wdata;
            `LXT_OFF_DAH: nxt_st.dah = i_wdata;
            `LXT_OFF_DAX: nxt_st.dax = i_wdata & `LXT_DAX_WMASK;
            `LXT_OFF_ETYP: nxt_st.etyp = i_wdata;
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            `LXT_OFF_TXST2: nxt_st.rdata = txst;
            `LXT_OFF_MODE: nxt_st.rdata = st_ff.mode;
            `LXT_OFF_DAL: nxt_st.rdata = st_ff.dal;
            `LXT_OFF_DAM: nxt_st.rdata = st_ff.dam;
            `LXT_OFF_DAH: nxt_st.rdata = st_ff.dah;
            `LXT_OFF_DAX: nxt_st.rdata = st_ff.dax;
            `LXT_OFF_ETYP: nxt_st.rdata = st_ff.etyp;
            default: nxt_st.rdata = 16'h0000;
         endcase
      end
      // Gigabit operation is only offered while the single port mode is set.
      nxt_st.gige_ok = ~nxt_st.mode[`LXT_MD_DUAL];
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_ff.mode <= `LXT_RST_MODE;
         st_ff.dal <= `LXT_RST_DA;
         st_ff.dam <= `LXT_RST_DA;
         st_ff.dah <= `LXT_RST_DA;
         st_ff.dax <= `LXT_RST_DAX;
         st_ff.etyp <= `LXT_RST_ETYP;
         st_ff.rdata <= `LXT_RST_TXST2;
         st_ff.gige_ok <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_rdata = st_ff.rdata;
   assign o_dual_port_select = st_ff.mode[`LXT_MD_DUAL];
   assign o_gige_allowed = st_ff.gige_ok;

   // -------------------------------------------------------------------------
   // Transmit status of port 2
   // -------------------------------------------------------------------------
   assign tx_err = {i_half_duplex, i_tx_jabber, i_tx_flushed, i_tx_carrier_lost,
      i_tx_no_carrier, i_tx_late_coll, i_tx_excess_coll, i_tx_excess_deferral, i_tx_underflow};

   lxt_txstat u_txstat (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_start(i_tx_attempt),
      .i_err(tx_err),
      .i_coll(i_tx_collision),
      .i_defer(i_tx_deferring),
      .o_st(txst)
   );

   // -------------------------------------------------------------------------
   // Extract trap
   // -------------------------------------------------------------------------
   // Port 2 is honoured only in dual port mode; in single port mode a stale
   // select bit would otherwise trap a port that carries no traffic.
   assign src_port2 = st_ff.mode[`LXT_MD_SRC] & st_ff.mode[`LXT_MD_DUAL];
   assign hdr1 = {i_rx1_da, i_rx1_etype, i_rx1_vlan_hit, i_rx1_queue_fwd};
   assign hdr2 = {i_rx2_da, i_rx2_etype, i_rx2_vlan_hit, i_rx2_queue_fwd};
   assign tif.hv = src_port2 ? i_rx2_valid : i_rx1_valid;
   assign tif.hdr = src_port2 ? hdr2 : hdr1;
   assign tif.mgmt_en = st_ff.mode[`LXT_MD_MGMT];
   assign tif.bcast_en = st_ff.mode[`LXT_MD_BCAST];
   assign tif.vlan_en = st_ff.mode[`LXT_MD_VLAN];
   assign tif.etype_en = st_ff.mode[`LXT_MD_ETYP];
   assign tif.da_en = st_ff.mode[`LXT_MD_DA];
   assign tif.addr = {st_ff.dah, st_ff.dam, st_ff.dal};
   assign tif.mask = st_ff.dax[7:0];
   assign tif.etype = st_ff.etyp;

   lxt_trap u_trap (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .t(tif)
   );

   assign o_rx_extract = tif.extract;
   assign o_rx_queue_fwd = tif.fwd;
   assign o_rx_done = tif.done;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   property p_err_summary;
      txst.err == (txst.jab | txst.flush | txst.loc | txst.noc | txst.lc | txst.ec
         | txst.exd);
   endproperty
   a_err_summary: assert property (p_err_summary)
      else $error("error summary disagrees with error flags");

   property p_jabber;
      i_tx_jabber |=> txst.jab && txst.err;
   endproperty
   a_jabber: assert property (p_jabber)
      else $error("jabber flag not set");

   property p_flush;
      i_tx_flushed |=> txst.flush && txst.err;
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush flag not set");

   property p_carrier_lost;
      i_tx_carrier_lost |=> txst.loc && txst.err;
   endproperty
   a_carrier_lost: assert property (p_carrier_lost)
      else $error("carrier lost flag not set");

   property p_no_carrier;
      i_tx_no_carrier |=> txst.noc && txst.err;
   endproperty
   a_no_carrier: assert property (p_no_carrier)
      else $error("no carrier flag not set");

   property p_late_coll;
      i_tx_late_coll |=> txst.lc && txst.err;
   endproperty
   a_late_coll: assert property (p_late_coll)
      else $error("late collision flag not set");

   property p_excess_coll;
      i_tx_excess_coll |=> txst.ec && txst.err;
   endproperty
   a_excess_coll: assert property (p_excess_coll)
      else $error("excess collision flag not set");

   property p_coll_count;
      i_tx_collision && !i_tx_attempt && txst.cc != `LXT_CC_MAX
         |=> txst.cc == $past(txst.cc) + 4'h1;
   endproperty
   a_coll_count: assert property (p_coll_count)
      else $error("collision count did not advance");

   property p_excess_defer;
      i_tx_excess_deferral |=> txst.exd && txst.err;
   endproperty
   a_excess_defer: assert property (p_excess_defer)
      else $error("excess deferral flag not set");

   property p_underflow;
      i_tx_underflow |=> txst.ufe;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("underflow flag not set");

   property p_deferring;
      ##1 txst.def == $past(i_tx_deferring && i_half_duplex);
   endproperty
   a_deferring: assert property (p_deferring)
      else $error("deferring flag wrong");

   property p_restart;
      i_tx_attempt && tx_err[7:0] == 8'h00 && !i_tx_collision
         |=> txst.cc == 4'h0 && !txst.err && !txst.ufe;
   endproperty
   a_restart: assert property (p_restart)
      else $error("status not cleared at new attempt");

   property p_exclusive;
      o_rx_extract |-> !o_rx_queue_fwd && o_rx_done;
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("frame sent to queue and extract");

   property p_mgmt;
      tif.hv && tif.mgmt_en && tif.hdr.da[47:24] == `LXT_MGMT_PFX |=> o_rx_extract;
   endproperty
   a_mgmt: assert property (p_mgmt)
      else $error("management frame not trapped");

   property p_bcast;
      tif.hv && tif.bcast_en && tif.hdr.da == `LXT_BCAST_DA |=> o_rx_extract;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast frame not trapped");

   property p_source;
      i_rx2_valid && !i_rx1_valid && !src_port2 |=> !o_rx_done;
   endproperty
   a_source: assert property (p_source)
      else $error("unselected port classified");

   property p_vlan;
      tif.hv && tif.hdr.vlan_hit |=> o_rx_extract == $past(tif.vlan_en) || o_rx_extract;
   endproperty
   a_vlan: assert property (p_vlan)
      else $error("vlan trap not applied");

   property p_etype;
      tif.hv && tif.etype_en && tif.hdr.etype == st_ff.etyp |=> o_rx_extract;
   endproperty
   a_etype: assert property (p_etype)
      else $error("protocol type frame not trapped");

   property p_da_mask;
      tif.hv && tif.da_en && tif.hdr.da[47:8] == tif.addr[47:8]
         && ((tif.hdr.da[7:0] ^ tif.addr[7:0]) & ~tif.mask) == 8'h00 |=> o_rx_extract;
   endproperty
   a_da_mask: assert property (p_da_mask)
      else $error("masked address frame not trapped");

   property p_no_trap;
      tif.hv && st_ff.mode[9:8] == 2'b00 && st_ff.mode[3:1] == 3'b000
         |=> !o_rx_extract && o_rx_queue_fwd == $past(tif.hdr.queue_fwd);
   endproperty
   a_no_trap: assert property (p_no_trap)
      else $error("trap fired with all traps off");

   sequence s_wr_dal;
      i_wr && i_addr == `LXT_OFF_DAL;
   endsequence
   sequence s_rd_dal;
      i_rd && i_addr == `LXT_OFF_DAL && !i_wr;
   endsequence
   property p_addr_low;
      s_wr_dal ##1 s_rd_dal |=> o_rdata == $past(i_wdata, 2) && tif.addr[15:0] == o_rdata;
   endproperty
   a_addr_low: assert property (p_addr_low)
      else $error("trap address low word wrong");

   property p_mask_bits;
      ##1 o_rdata[15:8] == 8'h00 || !$past(i_rd && i_addr == `LXT_OFF_DAX);
   endproperty
   a_mask_bits: assert property (p_mask_bits)
      else $error("mask register upper byte not zero");

   property p_mode;
      i_wr && i_addr == `LXT_OFF_MODE
         |=> o_dual_port_select == $past(i_wdata[0]) && o_gige_allowed == !$past(i_wdata[0]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("port mode not taken");

   property p_etype_low;
      i_wr && i_addr == `LXT_OFF_ETYP |=> tif.etype[7:0] == $past(i_wdata[7:0]);
   endproperty
   a_etype_low: assert property (p_etype_low)
      else $error("protocol type low byte misplaced");

   property p_read_once;
      !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_read_once: assert property (p_read_once)
      else $error("read data outside its cycle");
endmodule

// *** tb/lxt_top_tb.sv ***
// Self-checking bench for the LAN trap and port 2 transmit status register bank.
`include "lxt_regs.svh"
module lxt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic i_tx_attempt = 1'b0;
   logic [8:0] tx_ev = 9'h000;
   logic i_tx_deferring = 1'b0;
   logic i_half_duplex = 1'b0;
   logic i_rx1_valid = 1'b0;
   logic i_rx2_valid = 1'b0;
   logic [47:0] rx_da = 48'h000000000000;
   logic [15:0] rx_et = 16'h0000;
   logic rx_vh = 1'b0;
   logic rx_qf = 1'b0;
   logic o_dual_port_select;
   logic o_gige_allowed;
   logic o_rx_extract;
   logic o_rx_queue_fwd;
   logic o_rx_done;
   int err_count = 0;
   int num_checks = 0;
   logic [15:0] ev_exp [8] = '{16'hC000, 16'hA000, 16'h8800, 16'h8400, 16'h8200, 16'h8100,
      16'h8004, 16'h0002};

   lxt_top dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_attempt(i_tx_attempt),
      .i_tx_jabber(tx_ev[0]), .i_tx_flushed(tx_ev[1]), .i_tx_carrier_lost(tx_ev[2]),
      .i_tx_no_carrier(tx_ev[3]), .i_tx_late_coll(tx_ev[4]), .i_tx_excess_coll(tx_ev[5]),
      .i_tx_excess_deferral(tx_ev[6]), .i_tx_underflow(tx_ev[7]), .i_tx_collision(tx_ev[8]),
      .i_tx_deferring(i_tx_deferring), .i_half_duplex(i_half_duplex),
      .i_rx1_valid(i_rx1_valid), .i_rx1_da(rx_da), .i_rx1_etype(rx_et),
      .i_rx1_vlan_hit(rx_vh), .i_rx1_queue_fwd(rx_qf),
      .i_rx2_valid(i_rx2_valid), .i_rx2_da(rx_da), .i_rx2_etype(rx_et),
      .i_rx2_vlan_hit(rx_vh), .i_rx2_queue_fwd(rx_qf),
      .o_dual_port_select(o_dual_port_select), .o_gige_allowed(o_gige_allowed),
      .o_rx_extract(o_rx_extract), .o_rx_queue_fwd(o_rx_queue_fwd), .o_rx_done(o_rx_done));

   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      // A following write raises the strobe in a later time step, never beside this drop.
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   task automatic tx(input logic att, input logic [8:0] ev);
      i_tx_attempt <= att;
      tx_ev <= ev;
      @(posedge i_core_clk);
      i_tx_attempt <= 1'b0;
      tx_ev <= 9'h000;
      #1;
   endtask

   // Result is packed as done, extract, queue forward.
   task automatic hdr(input logic p2, input logic [47:0] da, input logic [15:0] et,
      input logic vh, input logic qf, input logic [2:0] exp);
      i_rx1_valid <= !p2;
      i_rx2_valid <= p2;
      rx_da <= da;
      rx_et <= et;
      rx_vh <= vh;
      rx_qf <= qf;
      @(posedge i_core_clk);
      i_rx1_valid <= 1'b0;
      i_rx2_valid <= 1'b0;
      #1;
      chk({13'h0000, o_rx_done, o_rx_extract, o_rx_queue_fwd}, {13'h0000, exp});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      chk({14'h0000, o_dual_port_select, o_gige_allowed}, 16'h0001);
      for (int i = 0; i < 8; i++) begin
         rd(8'hBC + 8'(2 * i), 16'h0000);
      end
      wr(`LXT_OFF_MODE, 16'hFFFF);
      rd(`LXT_OFF_MODE, 16'h031F);
      #1;
      chk({14'h0000, o_dual_port_select, o_gige_allowed}, 16'h0002);
      wr(`LXT_OFF_DAX, 16'hFFFF);
      rd(`LXT_OFF_DAX, 16'h00FF);
      wr(`LXT_OFF_TXST2, 16'hFFFF);
      wr(8'hCC, 16'hFFFF);
      rd(`LXT_OFF_TXST2, 16'h0000);
      rd(8'hCC, 16'h0000);
      wr(`LXT_OFF_DAL, 16'h1234);
      rd(`LXT_OFF_DAL, 16'h1234);
      wr(`LXT_OFF_ETYP, 16'h0806);
      rd(`LXT_OFF_ETYP, 16'h0806);
      wr(`LXT_OFF_MODE, 16'h0000);
   endtask

   task automatic t_tx();
      tx(1'b1, 9'h000);
      tx(1'b0, 9'h100);
      tx(1'b0, 9'h010);
      rd(`LXT_OFF_TXST2, 16'h8208);
      for (int i = 0; i < 8; i++) begin
         tx(1'b1, 9'h000);
         tx(1'b0, 9'(1 << i));
         rd(`LXT_OFF_TXST2, ev_exp[i]);
      end
      tx(1'b1, 9'h000);
      rd(`LXT_OFF_TXST2, 16'h0000);
      tx(1'b1, 9'h100);
      rd(`LXT_OFF_TXST2, 16'h0008);
      for (int i = 0; i < 17; i++) begin
         tx(1'b0, 9'h100);
      end
      rd(`LXT_OFF_TXST2, 16'h0078);
      tx(1'b1, 9'h000);
      i_tx_deferring <= 1'b1;
      i_half_duplex <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      rd(`LXT_OFF_TXST2, 16'h0001);
      i_half_duplex <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      rd(`LXT_OFF_TXST2, 16'h0000);
      i_tx_deferring <= 1'b0;
   endtask

   task automatic t_trap();
      hdr(1'b0, 48'hFFFFFFFFFFFF, 16'h0800, 1'b1, 1'b1, 3'b101);
      wr(`LXT_OFF_MODE, 16'h0100);
      hdr(1'b0, 48'hFFFFFFFFFFFF, 16'h0800, 1'b0, 1'b1, 3'b110);
      hdr(1'b0, 48'hFFFFFFFFFFFE, 16'h0800, 1'b0, 1'b0, 3'b100);
      wr(`LXT_OFF_MODE, 16'h0200);
      hdr(1'b0, 48'h0180C2ABCDEF, 16'h0800, 1'b0, 1'b0, 3'b110);
      hdr(1'b0, 48'h0180C3000000, 16'h0800, 1'b0, 1'b1, 3'b101);
      wr(`LXT_OFF_DAH, 16'h0180);
      wr(`LXT_OFF_DAM, 16'hC200);
      wr(`LXT_OFF_DAL, 16'h0010);
      wr(`LXT_OFF_DAX, 16'h0011);
      wr(`LXT_OFF_MODE, 16'h0002);
      hdr(1'b0, 48'h0180C2000000, 16'h0800, 1'b0, 1'b0, 3'b110);
      hdr(1'b0, 48'h0180C2000011, 16'h0800, 1'b0, 1'b0, 3'b110);
      hdr(1'b0, 48'h0180C2000002, 16'h0800, 1'b0, 1'b0, 3'b100);
      hdr(1'b0, 48'h0180C2010010, 16'h0800, 1'b0, 1'b0, 3'b100);
      wr(`LXT_OFF_ETYP, 16'h88F7);
      wr(`LXT_OFF_MODE, 16'h0004);
      hdr(1'b0, 48'h000000000001, 16'h88F7, 1'b0, 1'b1, 3'b110);
      hdr(1'b0, 48'h000000000001, 16'h88F6, 1'b0, 1'b0, 3'b100);
      wr(`LXT_OFF_MODE, 16'h0008);
      hdr(1'b0, 48'h000000000001, 16'h88F6, 1'b1, 1'b1, 3'b110);
      hdr(1'b0, 48'h000000000001, 16'h88F6, 1'b0, 1'b0, 3'b100);
      wr(`LXT_OFF_MODE, 16'h0111);
      hdr(1'b1, 48'hFFFFFFFFFFFF, 16'h0800, 1'b0, 1'b0, 3'b110);
      hdr(1'b0, 48'hFFFFFFFFFFFF, 16'h0800, 1'b0, 1'b0, 3'b000);
      wr(`LXT_OFF_MODE, 16'h0110);
      hdr(1'b1, 48'hFFFFFFFFFFFF, 16'h0800, 1'b0, 1'b0, 3'b000);
      hdr(1'b0, 48'hFFFFFFFFFFFF, 16'h0800, 1'b0, 1'b0, 3'b110);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      #1;
      t_regs();
      t_tx();
      t_trap();
      final_report();
   end

   // A hang is cut short here and counted as a mismatch.
   initial begin
      repeat (5000) @(posedge i_core_clk);
      err_count++;
      final_report();
   end
endmodule
